// >>> src/jitter_attenuator.sv
// Jitter attenuator: elastic rail FIFO and digital smoothing loop
// What this block does
// - Digital loop locks to the jittery line clock, making a same-rate smoothed clock
// - Smoothed clock drives the smoothed clock output pin
// - Data is written on line clock edges and read on smoothed clock edges
// - Limit flag rises when occupancy is within 2 of full
// - FIFO carries both rails with selectable depth of 16 or 32
// - Read data appears on smoothed rail outputs, timed by the smoothed clock
// - Loop gain set by bandwidth select; rate mode sets the nominal step offset
// - Gapped input clock yields a continuous, ungapped smoothed clock
// - Positive rail sampled on falling line edge when edge select high, else rising
`timescale 1ns/1ps
`include "jitter_attenuator_map.svh"

module rail_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32,
   parameter int PTR_W = 5
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   // Depth control
   input  wire logic [PTR_W:0]   depth_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o,
   // Occupancy
   output logic [PTR_W:0]        level_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0]   count;
   wire              do_write = in_valid_i & in_ready_o;
   wire              do_read  = out_valid_o & out_ready_i;
   // Pointers wrap at the selected depth, so the depth may change only in reset
   wire [PTR_W-1:0]  last     = PTR_W'(depth_i - 1'b1);
   // A full buffer refuses the write and the caller drops it

   assign in_ready_o  = (count < depth_i);
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign level_o     = count;

   always_ff @(posedge ref_clk_i) begin
      if (do_write) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_write) begin
            wr_ptr <= (wr_ptr == last) ? '0 : wr_ptr + 1'b1;
         end
         if (do_read) begin
            rd_ptr <= (rd_ptr == last) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (PTR_W+1)'(do_write) - (PTR_W+1)'(do_read);
      end
   end
endmodule : rail_fifo

module jitter_attenuator (
   // Clock and reset
   input  wire logic                               ref_clk_i,
   input  wire logic                               sys_rst_i,
   // Line side
   input  wire logic                               line_clock_i,
   input  wire logic                               positive_rail_in_i,
   input  wire logic                               negative_rail_in_i,
   // Configuration
   input  wire logic                               sample_edge_select_i,
   input  wire logic                               loop_bandwidth_select_i,
   input  wire logic                               deep_fifo_select_i,
   input  wire jitter_attenuator_pkg::rate_mode_type rate_mode_i,
   // Terminal side
   output logic                                    smoothed_clock_out_o,
   output logic                                    smoothed_positive_rail_out_o,
   output logic                                    smoothed_negative_rail_out_o,
   // Status
   output logic                                    fifo_limit_flag_o
);
   localparam int PW = `FIFO_PTR_W;
   localparam int NW = `NCO_W;

   // Depth and loop centre both follow the synchronised depth select
   function automatic logic [PW:0] fill_depth(input logic deep);
      return deep ? (PW+1)'(`FIFO_DEPTH_MAX) : (PW+1)'(`FIFO_DEPTH_SMALL);
   endfunction : fill_depth
   function automatic logic [PW:0] fill_centre(input logic deep);
      return deep ? (PW+1)'(`FIFO_CENTRE_LARGE) : (PW+1)'(`FIFO_CENTRE_SMALL);
   endfunction : fill_centre

   // Two-stage synchronisers, three for the line clock; its edges are read from stages two and three
   logic [2:0] clk_s;
   logic [1:0] pos_s1, pos_s2, neg_s1, neg_s2;
   logic       ces_s1, ces_s2, bws_s1, bws_s2, dsel_s1, dsel_s2;
   // Rate mode is a pin as well, so it gets the same two stages
   jitter_attenuator_pkg::rate_mode_type rate_s1, rate_s2;

   always_ff @(posedge ref_clk_i) begin
      clk_s   <= {clk_s[1:0], line_clock_i};
      pos_s1  <= {pos_s1[0], positive_rail_in_i};
      neg_s1  <= {neg_s1[0], negative_rail_in_i};
      ces_s1  <= sample_edge_select_i;
      ces_s2  <= ces_s1;
      bws_s1  <= loop_bandwidth_select_i;
      bws_s2  <= bws_s1;
      dsel_s1 <= deep_fifo_select_i;
      dsel_s2 <= dsel_s1;
      rate_s1 <= rate_mode_i;
      rate_s2 <= rate_s1;
   end
   assign pos_s2 = pos_s1;
   assign neg_s2 = neg_s1;

   // Edge detection on synchronised line clock
   wire line_rise  = clk_s[1] & ~clk_s[2];
   wire line_fall  = ~clk_s[1] & clk_s[2];
   wire pos_sample = ces_s2 ? line_fall : line_rise;
   // Rail data is aligned with the clock stages it travelled beside
   wire line_push  = pos_sample;

   // FIFO
   wire [PW:0] depth  = fill_depth(dsel_s2);
   // Centre is where the loop wants the fill level to sit
   wire [PW:0] centre = fill_centre(dsel_s2);
   jitter_attenuator_pkg::rail_pair_type wr_word, rd_word;
   assign wr_word.positive_rail = pos_s2[1];
   assign wr_word.negative_rail = neg_s2[1];
   logic       fifo_in_ready, fifo_out_valid, read_strobe;
   logic [PW:0] level;

   rail_fifo #(.WIDTH(2), .DEPTH(`FIFO_DEPTH_MAX), .PTR_W(PW)) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .sys_rst_i   (sys_rst_i),
      .depth_i     (depth),
      .in_valid_i  (line_push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (wr_word),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (read_strobe),
      .out_data_o  (rd_word),
      .level_o     (level)
   );

   // Smoothing loop: NCO steered by fill error, gain from bandwidth, step offset from rate
   logic [NW-1:0] step, phase;
   wire  [NW:0]   phase_sum = {1'b0, phase} + {1'b0, step};
   logic [NW-1:0] rate_bias;
   always_comb begin
      case (rate_s2)
         jitter_attenuator_pkg::RATE_E3:   rate_bias = `RATE_BIAS_E3;
         jitter_attenuator_pkg::RATE_DS3:  rate_bias = `RATE_BIAS_DS3;
         jitter_attenuator_pkg::RATE_STS1: rate_bias = `RATE_BIAS_STS1;
         default:                          rate_bias = `RATE_BIAS_E3;
      endcase
   end
   wire signed [NW-1:0] fill_err = NW'($signed({1'b0, level}) - $signed({1'b0, centre}));
   wire [4:0] gain_shift = bws_s2 ? 5'(`GAIN_SHIFT_HIGH_BW)
                                  : 5'(`GAIN_SHIFT_LOW_BW);
   // Small correction proportional to fill error per line edge keeps bandwidth narrow, which is the point
   wire signed [NW-1:0] correction = (fill_err <<< (NW/2)) >>> gain_shift;
   // Nominal step must match the line rate; the loop only trims a small offset
   wire [NW-1:0] next_step = NW'(`NCO_STEP_RESET) + rate_bias + NW'(correction);

   // Smoothed clock runs at half the NCO overflow rate, never gaps
   wire nco_tick = phase_sum[NW];
   logic smooth_clk;
   wire  next_smooth_clk = smooth_clk ^ nco_tick;
   assign read_strobe = nco_tick & smooth_clk;
   // Underflow repeats zeros rather than stale data
   wire pos_out = fifo_out_valid & rd_word.positive_rail;
   wire neg_out = fifo_out_valid & rd_word.negative_rail;
   // Limit flag follows the live fill level in both directions
   wire near_full = (level >= depth - (PW+1)'(`FIFO_LIMIT_MARGIN));

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         phase      <= '0;
         step       <= `NCO_STEP_RESET;
         smooth_clk <= 1'b0;
      end else begin
         phase <= phase_sum[NW-1:0];
         if (line_push) begin
            step <= next_step;
         end
         if (nco_tick) begin
            smooth_clk <= next_smooth_clk;
         end
      end
   end

   // Outputs registered; data changes on smoothed clock falling edge
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         smoothed_clock_out_o         <= 1'b0;
         smoothed_positive_rail_out_o <= 1'b0;
         smoothed_negative_rail_out_o <= 1'b0;
         fifo_limit_flag_o            <= 1'b0;
      end else begin
         // Clock and data share one register stage, so data moves as the clock falls
         smoothed_clock_out_o <= next_smooth_clk;
         if (read_strobe) begin
            smoothed_positive_rail_out_o <= pos_out;
            smoothed_negative_rail_out_o <= neg_out;
         end
         fifo_limit_flag_o <= near_full;
      end
   end
   // Writes on full are dropped; the limit flag warns two bits ahead
   wire unused_ready = fifo_in_ready;
endmodule : jitter_attenuator

// >>> src/jitter_attenuator_map.svh
// Constants of the elastic buffer and the digital smoothing loop
`ifndef JITTER_ATTENUATOR_MAP_SVH
`define JITTER_ATTENUATOR_MAP_SVH
`define FIFO_DEPTH_MAX      32
`define FIFO_DEPTH_SMALL    16
`define FIFO_PTR_W          5
`define FIFO_LIMIT_MARGIN   2
`define FIFO_CENTRE_SMALL   8
`define FIFO_CENTRE_LARGE   16
`define NCO_W               24
`define NCO_STEP_RESET      24'h400000
`define GAIN_SHIFT_LOW_BW   8
`define GAIN_SHIFT_HIGH_BW  4
`define RATE_BIAS_E3        24'h000000
`define RATE_BIAS_DS3       24'h000100
`define RATE_BIAS_STS1      24'h000200
`endif

// >>> src/jitter_attenuator_pkg.sv
// Types of the jitter attenuator
package jitter_attenuator_pkg;
   typedef struct packed {
      logic positive_rail;
      logic negative_rail;
   } rail_pair_type;
   typedef enum logic [1:0] {
      RATE_E3,
      RATE_DS3,
      RATE_STS1
   } rate_mode_type;
endpackage : jitter_attenuator_pkg

// >>> testbench/jitter_attenuator_asserts.sv
// Port checker of the jitter attenuator
`timescale 1ns/1ps
module jitter_attenuator_asserts (
   // Watched ports
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic line_clock_i,
   input wire logic smoothed_clock_out_o,
   input wire logic smoothed_positive_rail_out_o,
   input wire logic smoothed_negative_rail_out_o,
   input wire logic fifo_limit_flag_o
);
   logic [7:0] line_age;
   wire [1:0]  rails = {smoothed_positive_rail_out_o, smoothed_negative_rail_out_o};
   wire        sck = smoothed_clock_out_o;
   wire        flag = fifo_limit_flag_o;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // Ages saturate so a long idle span stays visible
   always_ff @(posedge ref_clk_i) begin
      line_age <= (sys_rst_i || $changed(line_clock_i)) ? 8'h00 : line_age + {7'h00, ~&line_age};
   end
   chk_rst_quiet: assert property (disable iff (1'b0) sys_rst_i |=> !sck && !flag && !rails)
      else $error("outputs not cleared");
   chk_flag_wakes_low: assert property ($fell(sys_rst_i) |-> (!flag) [*8])
      else $error("flag early");
   chk_rails_wake_zero: assert property ($fell(sys_rst_i) |-> (rails == 2'b00) [*3])
      else $error("rails early");
   chk_clk_starts: assert property ($fell(sys_rst_i) |-> ##[1:32] sck)
      else $error("clock idle");
   chk_clk_period: assert property ($changed(sck) |=> $stable(sck) ##[2:6] $changed(sck))
      else $error("clock phase length");
   chk_rail_timing: assert property ($changed(rails) |-> $fell(sck))
      else $error("rails off clock");
   chk_flag_needs_write: assert property ($rose(flag) |-> line_age < 8'h08)
      else $error("flag without write");
   chk_flag_clears_idle: assert property (line_age == 8'hff |-> !flag)
      else $error("flag stuck");
   cover property ($rose(flag));
   cover property ($fell(flag));
   cover property (line_age == 8'hff && $changed(sck));
endmodule : jitter_attenuator_asserts
bind jitter_attenuator jitter_attenuator_asserts chk (.ref_clk_i, .sys_rst_i, .line_clock_i,
   .smoothed_clock_out_o, .smoothed_positive_rail_out_o, .smoothed_negative_rail_out_o,
   .fifo_limit_flag_o);

// >>> testbench/jitter_attenuator_test.sv
// Bench of the jitter attenuator
`timescale 1ns/1ps
module jitter_attenuator_test;
   typedef struct packed {
      logic                                 sel;
      logic                                 bw;
      logic                                 deep;
      jitter_attenuator_pkg::rate_mode_type rate;
      logic [15:0]                          data;
   } row_type;
   // Positive byte keeps its top bit set: it marks the first bit read out
   row_type rows [3] = '{21'h00a53c, 21'h1d96c3, 21'h16f00f};
   logic ref_clk_i, sys_rst_i, sample_edge_select_i, loop_bandwidth_select_i, deep_fifo_select_i;
   jitter_attenuator_pkg::rate_mode_type rate_mode_i;
   wire line_clock_i, positive_rail_in_i, negative_rail_in_i, smoothed_clock_out_o;
   wire smoothed_positive_rail_out_o, smoothed_negative_rail_out_o, fifo_limit_flag_o;
   int failures, compares;
   logic [7:0] gp, gn;
   logic seen;
   jitter_attenuator dut (.ref_clk_i, .sys_rst_i, .line_clock_i, .positive_rail_in_i,
      .negative_rail_in_i, .sample_edge_select_i, .loop_bandwidth_select_i,
      .deep_fifo_select_i, .rate_mode_i, .smoothed_clock_out_o, .smoothed_positive_rail_out_o,
      .smoothed_negative_rail_out_o, .fifo_limit_flag_o);
   line_source src (.sample_edge_select_i, .line_clock_o(line_clock_i),
      .positive_rail_o(positive_rail_in_i), .negative_rail_o(negative_rail_in_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : check
   task automatic close_out();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic do_reset();
      sys_rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      check("reset outputs", 8'h00, {4'h0, smoothed_clock_out_o, smoothed_positive_rail_out_o,
         smoothed_negative_rail_out_o, fifo_limit_flag_o});
      sys_rst_i = 1'b0;
   endtask : do_reset
   task automatic grab();
      int k;
      logic last;
      k = 0;
      last = 1'b1;
      for (int t = 0; t < 2000 && k < 8; t++) begin
         @(negedge ref_clk_i);
         if (smoothed_clock_out_o && !last && (k > 0 || smoothed_positive_rail_out_o)) begin
            gp = {gp[6:0], smoothed_positive_rail_out_o};
            gn = {gn[6:0], smoothed_negative_rail_out_o};
            k++;
         end
         last = smoothed_clock_out_o;
      end
   endtask : grab
   initial begin
      failures = 0;
      compares = 0;
      {sample_edge_select_i, loop_bandwidth_select_i, deep_fifo_select_i} = 3'b000;
      rate_mode_i = jitter_attenuator_pkg::RATE_E3;
      do_reset();
      foreach (rows[i]) begin
         sample_edge_select_i = rows[i].sel;
         loop_bandwidth_select_i = rows[i].bw;
         deep_fifo_select_i = rows[i].deep;
         rate_mode_i = rows[i].rate;
         do_reset();
         fork
            src.send({32'h0, rows[i].data[15:8]}, {32'h0, rows[i].data[7:0]}, 8, 80);
            grab();
         join
         check("positive rail", rows[i].data[15:8], gp);
         check("negative rail", rows[i].data[7:0], gn);
         repeat (200) @(negedge ref_clk_i);
      end
      // Fast stretch of a gapped clock outruns the smoothed clock and fills the shallow buffer
      {sample_edge_select_i, loop_bandwidth_select_i, deep_fifo_select_i} = 3'b000;
      do_reset();
      seen = 1'b0;
      fork
         begin
            src.send(40'hffffffffff, 40'h0, 40, 50);
            src.send(40'hffffffffff, 40'h0, 40, 50);
         end
         repeat (500) begin
            @(negedge ref_clk_i);
            seen = seen | fifo_limit_flag_o;
         end
      join
      check("limit flag seen", 8'h01, {7'h0, seen});
      repeat (300) @(negedge ref_clk_i);
      check("limit flag idle", 8'h00, {7'h0, fifo_limit_flag_o});
      fork
         src.send(40'hffffffffff, 40'hffffffffff, 16, 80);
         begin
            repeat (40) @(negedge ref_clk_i);
            do_reset();
         end
      join
      close_out();
   end
   initial begin
      #400000;
      failures++;
      close_out();
   end
endmodule : jitter_attenuator_test

// >>> testbench/line_source.sv
// Line-side source: gapped line clock with two rails
`timescale 1ns/1ps
module line_source (
   // Configuration
   input  wire logic sample_edge_select_i,
   // Line side
   output logic      line_clock_o,
   output logic      positive_rail_o,
   output logic      negative_rail_o
);
   logic [1:0] b;
   initial {line_clock_o, positive_rail_o, negative_rail_o} = 3'b000;
   // Clock stands low between frames; rails hold the inverse away from the sampled edge
   // A short quarter period q makes the fast stretch of a gapped clock
   task automatic send(input logic [39:0] p, input logic [39:0] n, input int bits, input int q);
      #13;
      for (int i = bits - 1; i >= 0; i--) begin
         b = {p[i], n[i]};
         #(q) {positive_rail_o, negative_rail_o} = sample_edge_select_i ? ~b : b;
         #(q) line_clock_o = 1'b1;
         #(q) {positive_rail_o, negative_rail_o} = sample_edge_select_i ? b : ~b;
         #(q) line_clock_o = 1'b0;
      end
   endtask : send
endmodule : line_source
